// >>> card_regs.sv
// relative address and specific-data register bank of the card
`timescale 1ns/1ps
`default_nettype none
// How it works
// - a 16-bit relative address register holds the address the host assigns during identification.
// - after identification the card answers selects and data requests only when they carry its own address.
// - after reset the relative address reads 0x0001 until the host assigns another.
// - address 0x0000 is never taken as an address, and a select carrying it sends a card in transfer back to stand-by.
// - only W or E class fields change, and only through the program command; others ignore it.
// - R fields are read-only; W and R/W fields both take one program and both show, since no field is hidden.
// - R/W/E and W/E fields rewrite freely and survive power loss, hardware reset and go-idle.
// - R/W/C_P fields clear on power or hardware reset, survive go-idle, accept one write once cleared.
// - R/W/E_P and W/E_P fields rewrite freely and fall back to default on any reset including go-idle.
// - the register shows structure code 3h at the top, version 4h, access times 27h and 01h.
// - read block length code 9h, with partial and misaligned reads all reported as not allowed.
// - write block length code 9h, partial writes not allowed, write speed factor 2h.
// - maximum bus clock code 32h and command class mask 0F5h.
// - erase group size and multiplier 1Fh, capacity code FFFh with multiplier 7h.
// - protect group size 0Fh and protect group enable set.
// - a 7-bit checksum sits in bits 7 to 1 and bit 0 always reads 1.
module card_regs (
    input  wire logic                    clk_i,
    input  wire logic                    rst_n_i,
    input  wire logic                    nv_init_i,
    input  wire logic                    bus_clk_i,
    input  wire card_regs_pkg::bus_cmd_t cmd_pin_i,
    output logic [15:0]                  rca_o,
    output card_regs_pkg::card_state_t   state_o,
    output logic                         resp_o,
    output logic                         data_valid_o,
    output logic [127:0]                 data_o
);
    import card_regs_pkg::*;

    // ----------------------------------------------------------------
    // command intake
    // ----------------------------------------------------------------
    bus_cmd_t cmd;

    bus_sampler u_sampler (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .bus_clk_i (bus_clk_i),
        .cmd_pin_i (cmd_pin_i),
        .cmd_o     (cmd)
    );

    logic        addr_hit;
    logic [15:0] cmd_addr;
    assign cmd_addr = cmd.arg[ARG_ADDR_LO +: 16];
    assign addr_hit = (cmd_addr == rca_o);

    logic is_idle;
    logic is_set;
    logic is_sel;
    logic is_send;
    logic is_prog;
    assign is_idle = cmd.valid && (cmd.index == CMD_GO_IDLE);
    assign is_set  = cmd.valid && (cmd.index == CMD_SET_ADDR);
    assign is_sel  = cmd.valid && (cmd.index == CMD_SELECT);
    assign is_send = cmd.valid && (cmd.index == CMD_SEND_DATA);
    assign is_prog = cmd.valid && (cmd.index == CMD_PROG_DATA);

    // ----------------------------------------------------------------
    // relative address and card state
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i || is_idle) begin
            rca_o <= RCA_DEFAULT;
        end else if (is_set && state_o == ST_IDENT
                     && cmd_addr != RCA_RESERVED) begin
            rca_o <= cmd_addr;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || is_idle) begin
            state_o <= ST_IDENT;
        end else begin
            case (state_o)
                ST_IDENT: begin
                    if (is_set && cmd_addr != RCA_RESERVED) begin
                        state_o <= ST_STANDBY;
                    end
                end
                ST_STANDBY: begin
                    if (is_sel && addr_hit) begin
                        state_o <= ST_TRANSFER;
                    end
                end
                ST_TRANSFER: begin
                    // a select for anyone else, address 0 included, parks us
                    if (is_sel && !addr_hit) begin
                        state_o <= ST_STANDBY;
                    end
                end
                default: begin
                    state_o <= ST_IDENT;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // specific-data storage
    // ----------------------------------------------------------------
    // nonvolatile bits have no power-on value here; nv_init_i stands in
    // for the factory load and must be pulsed once before use
    logic [127:0] image_r;
    logic         otp_done_r;
    logic         cp_done_r;
    logic [127:0] wmask;
    logic         prog_ok;
    logic [127:0] base;

    assign wmask   = write_mask_f(otp_done_r, cp_done_r);
    assign prog_ok = is_prog && state_o == ST_TRANSFER;
    assign base    = (CSD_DEFAULT & ~CRC_MASK)
                     | ({120'h0, crc7_f(CSD_DEFAULT[127:8]), 1'b0});

    always_ff @(posedge clk_i) begin
        if (nv_init_i) begin
            image_r <= base;
        end else if (!rst_n_i) begin
            // power/hardware reset: only E and OTP fields survive
            image_r <= (image_r & (NV_MASK | OTP_MASK))
                       | (CSD_DEFAULT & ~(NV_MASK | OTP_MASK));
        end else if (is_idle) begin
            image_r <= (image_r & ~EP_MASK)
                       | (CSD_DEFAULT & EP_MASK);
        end else if (prog_ok) begin
            // fixed and reserved bits are outside wmask
            image_r <= (image_r & ~wmask)
                       | (cmd.data & wmask);
        end
    end

    always_ff @(posedge clk_i) begin
        if (nv_init_i) begin
            otp_done_r <= 1'b0;
        end else if (prog_ok) begin
            otp_done_r <= 1'b1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cp_done_r <= 1'b0;
        end else if (prog_ok) begin
            cp_done_r <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // answers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            data_valid_o <= 1'b0;
            data_o       <= '0;
        end else begin
            data_valid_o <= is_send && addr_hit && state_o == ST_STANDBY;
            if (is_send && addr_hit && state_o == ST_STANDBY) begin
                // hidden classes read zero, bit 0 forced high
                data_o <= (image_r & READ_MASK) | ONE_BIT;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            resp_o <= 1'b0;
        end else begin
            resp_o <= is_idle ? 1'b0
                    : is_set ? (state_o == ST_IDENT
                                && cmd_addr != RCA_RESERVED)
                    : is_sel ? (addr_hit && state_o != ST_IDENT)
                    : is_send ? (addr_hit && state_o == ST_STANDBY)
                    : prog_ok;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    logic rst_q_r;
    always_ff @(posedge clk_i) begin
        rst_q_r <= rst_n_i;
    end

    property p_rca_default;
        @(posedge clk_i) rst_n_i && !rst_q_r |-> rca_o == RCA_DEFAULT;
    endproperty
    a_rca_default: assert property (p_rca_default)
        else $error("address not default after reset");

    property p_rca_nonzero;
        @(posedge clk_i) disable iff (!rst_n_i) rca_o != RCA_RESERVED;
    endproperty
    a_rca_nonzero: assert property (p_rca_nonzero)
        else $error("reserved address held");

    property p_assign;
        @(posedge clk_i) disable iff (!rst_n_i)
            is_set && state_o == ST_IDENT && cmd_addr != RCA_RESERVED
            |=> rca_o == $past(cmd_addr) && state_o == ST_STANDBY;
    endproperty
    a_assign: assert property (p_assign)
        else $error("address not taken");

    property p_deselect;
        @(posedge clk_i) disable iff (!rst_n_i)
            is_sel && cmd_addr == RCA_RESERVED && state_o == ST_TRANSFER
            |=> state_o == ST_STANDBY;
    endproperty
    a_deselect: assert property (p_deselect)
        else $error("select 0 did not park");

    property p_fixed;
        @(posedge clk_i) disable iff (!rst_n_i || nv_init_i)
            ##1 (image_r & FIXED_MASK) == (CSD_DEFAULT & FIXED_MASK);
    endproperty
    a_fixed: assert property (p_fixed)
        else $error("read-only field changed");

    property p_readout;
        @(posedge clk_i) disable iff (!rst_n_i)
            data_valid_o |-> data_o[0] && data_o[127:126] == STRUCTURE_CODE
            && data_o[83:80] == MAX_READ_BLOCK_LENGTH
            && data_o[25:22] == MAX_WRITE_BLOCK_LENGTH
            && data_o[36:32] == PROTECT_GROUP_SIZE;
    endproperty
    a_readout: assert property (p_readout)
        else $error("bad specific-data readout");

    property p_otp_once;
        @(posedge clk_i) disable iff (!rst_n_i || nv_init_i)
            prog_ok && otp_done_r |=> $stable(image_r & OTP_MASK);
    endproperty
    a_otp_once: assert property (p_otp_once)
        else $error("one-time field reprogrammed");

    property p_nv_keep;
        @(posedge clk_i) disable iff (nv_init_i)
            (is_idle || !rst_n_i) && !nv_init_i
            |=> $stable(image_r & NV_MASK);
    endproperty
    a_nv_keep: assert property (p_nv_keep)
        else $error("retained field lost on reset");

    property p_send_addr;
        @(posedge clk_i) disable iff (!rst_n_i)
            data_valid_o |-> $past(addr_hit) && $past(is_send);
    endproperty
    a_send_addr: assert property (p_send_addr)
        else $error("answered a foreign address");

    property p_prog_sel;
        @(posedge clk_i) disable iff (!rst_n_i || nv_init_i)
            is_prog && state_o != ST_TRANSFER |=> $stable(image_r);
    endproperty
    a_prog_sel: assert property (p_prog_sel)
        else $error("program accepted while not selected");

    c_assign: cover property (@(posedge clk_i) is_set && resp_o == 1'b0
                              ##1 resp_o);
    c_select: cover property (@(posedge clk_i) state_o == ST_TRANSFER);
    c_prog:   cover property (@(posedge clk_i) prog_ok);
    c_read:   cover property (@(posedge clk_i) data_valid_o);

endmodule
`default_nettype wire

// >>> card_regs_pkg.sv
// constants, types and helpers shared by the card address/specific-data bank
package card_regs_pkg;

    // ----------------------------------------------------------------
    // command indices on the card bus
    // ----------------------------------------------------------------
    localparam logic [5:0] CMD_GO_IDLE   = 6'h00;
    localparam logic [5:0] CMD_SET_ADDR  = 6'h03;
    localparam logic [5:0] CMD_SELECT    = 6'h07;
    localparam logic [5:0] CMD_SEND_DATA = 6'h09;
    localparam logic [5:0] CMD_PROG_DATA = 6'h1B;

    // ----------------------------------------------------------------
    // relative address
    // ----------------------------------------------------------------
    localparam logic [15:0] RCA_DEFAULT  = 16'h0001;
    localparam logic [15:0] RCA_RESERVED = 16'h0000;
    localparam int          ARG_ADDR_LO  = 16;

    // ----------------------------------------------------------------
    // specific-data field values
    // ----------------------------------------------------------------
    localparam logic [1:0]  STRUCTURE_CODE           = 2'h3;
    localparam logic [3:0]  SPEC_VERSION             = 4'h4;
    localparam logic [7:0]  ASYNC_READ_ACCESS_TIME   = 8'h27;
    localparam logic [7:0]  CLOCKED_READ_ACCESS_TIME = 8'h01;
    localparam logic [7:0]  MAX_BUS_CLOCK            = 8'h32;
    localparam logic [11:0] COMMAND_CLASS_MASK       = 12'h0F5;
    localparam logic [3:0]  MAX_READ_BLOCK_LENGTH    = 4'h9;
    localparam logic        PARTIAL_READ_ALLOWED     = 1'b0;
    localparam logic        WRITE_MISALIGN_ALLOWED   = 1'b0;
    localparam logic        READ_MISALIGN_ALLOWED    = 1'b0;
    localparam logic        DRIVER_STAGE_PRESENT     = 1'b0;
    localparam logic [11:0] CAPACITY_CODE            = 12'hFFF;
    localparam logic [2:0]  SUPPLY_CURRENT_CODE      = 3'h7;
    localparam logic [2:0]  CAPACITY_MULTIPLIER      = 3'h7;
    localparam logic [4:0]  ERASE_GROUP_SIZE         = 5'h1F;
    localparam logic [4:0]  ERASE_GROUP_MULTIPLIER   = 5'h1F;
    localparam logic [4:0]  PROTECT_GROUP_SIZE       = 5'h0F;
    localparam logic        PROTECT_GROUP_ON         = 1'b1;
    localparam logic [1:0]  DEFAULT_ECC_CODE         = 2'h0;
    localparam logic [2:0]  WRITE_SPEED_FACTOR       = 3'h2;
    localparam logic [3:0]  MAX_WRITE_BLOCK_LENGTH   = 4'h9;
    localparam logic        PARTIAL_WRITE_ALLOWED    = 1'b0;
    localparam logic        CONTENT_PROTECT          = 1'b0;
    localparam logic [1:0]  RSVD2                    = 2'h0;
    localparam logic [3:0]  RSVD4                    = 4'h0;

    localparam logic [127:0] CSD_DEFAULT = {
        STRUCTURE_CODE, SPEC_VERSION, RSVD2,
        ASYNC_READ_ACCESS_TIME, CLOCKED_READ_ACCESS_TIME, MAX_BUS_CLOCK,
        COMMAND_CLASS_MASK, MAX_READ_BLOCK_LENGTH,
        PARTIAL_READ_ALLOWED, WRITE_MISALIGN_ALLOWED,
        READ_MISALIGN_ALLOWED, DRIVER_STAGE_PRESENT, RSVD2,
        CAPACITY_CODE, SUPPLY_CURRENT_CODE, SUPPLY_CURRENT_CODE,
        SUPPLY_CURRENT_CODE, SUPPLY_CURRENT_CODE, CAPACITY_MULTIPLIER,
        ERASE_GROUP_SIZE, ERASE_GROUP_MULTIPLIER, PROTECT_GROUP_SIZE,
        PROTECT_GROUP_ON, DEFAULT_ECC_CODE, WRITE_SPEED_FACTOR,
        MAX_WRITE_BLOCK_LENGTH, PARTIAL_WRITE_ALLOWED, RSVD4,
        CONTENT_PROTECT, 16'h0001};

    // ----------------------------------------------------------------
    // per-bit access classes
    // ----------------------------------------------------------------
    localparam logic [127:0] OTP_MASK   = 128'h0000_0000_0000_0000_0000_0000_0000_EC00;
    localparam logic [127:0] NV_MASK    = 128'h0000_0000_0000_0000_0000_0000_0000_13FE;
    localparam logic [127:0] CP_MASK    = 128'h0;
    localparam logic [127:0] EP_MASK    = 128'h0;
    localparam logic [127:0] HIDDEN     = 128'h0;
    localparam logic [127:0] FIXED_MASK = ~(OTP_MASK | NV_MASK | CP_MASK | EP_MASK);
    localparam logic [127:0] READ_MASK  = ~HIDDEN;
    localparam logic [127:0] ONE_BIT    = 128'h1;
    localparam logic [127:0] CRC_MASK   = 128'hFE;
    localparam int           CRC_LO     = 1;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_IDENT   = 2'b00,
        ST_STANDBY = 2'b01,
        ST_TRANSFER = 2'b10
    } card_state_t;

    typedef struct packed {
        logic         valid;
        logic [5:0]   index;
        logic [31:0]  arg;
        logic [127:0] data;
    } bus_cmd_t;

    // checksum over the upper 120 bits, polynomial x^7 + x^3 + 1
    function automatic logic [6:0] crc7_f(input logic [119:0] d);
        logic [6:0] c;
        logic       fb;
        c = 7'h00;
        for (int i = 119; i >= 0; i--) begin
            fb = d[i] ^ c[6];
            c = {c[5:0], 1'b0};
            c[0] = fb;
            c[3] = c[3] ^ fb;
        end
        return c;
    endfunction

    // bits that a program command may change right now
    function automatic logic [127:0] write_mask_f(input logic otp_done,
                                                  input logic cp_done);
        return NV_MASK | EP_MASK | (otp_done ? 128'h0 : OTP_MASK)
               | (cp_done ? 128'h0 : CP_MASK);
    endfunction

endpackage

// >>> bus_sampler.sv
// samples the card bus clock and command fields into the core clock domain
`timescale 1ns/1ps
`default_nettype none
module bus_sampler (
    input  wire logic                   clk_i,
    input  wire logic                   rst_n_i,
    input  wire logic                   bus_clk_i,
    input  wire card_regs_pkg::bus_cmd_t cmd_pin_i,
    output card_regs_pkg::bus_cmd_t     cmd_o
);
    import card_regs_pkg::*;

    // ----------------------------------------------------------------
    // two-stage synchronisers; fields ride with the clock so they are
    // settled half a bus period before the sampled rising edge
    // ----------------------------------------------------------------
    logic     clk_s1_r;
    logic     clk_s2_r;
    logic     clk_s3_r;
    bus_cmd_t cmd_s1_r;
    bus_cmd_t cmd_s2_r;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            clk_s1_r <= 1'b0;
            clk_s2_r <= 1'b0;
            clk_s3_r <= 1'b0;
            cmd_s1_r <= '0;
            cmd_s2_r <= '0;
        end else begin
            clk_s1_r <= bus_clk_i;
            clk_s2_r <= clk_s1_r;
            clk_s3_r <= clk_s2_r;
            cmd_s1_r <= cmd_pin_i;
            cmd_s2_r <= cmd_s1_r;
        end
    end

    // ----------------------------------------------------------------
    // one-cycle command pulse on each bus clock rising edge
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            cmd_o <= '0;
        end else begin
            cmd_o       <= cmd_s2_r;
            cmd_o.valid <= cmd_s2_r.valid & clk_s2_r & ~clk_s3_r;
        end
    end

endmodule
`default_nettype wire

// >>> card_host_model.sv
// host-side model of the card bus: clock and command pins
`timescale 1ns/1ps
`default_nettype none
module card_host_model
    import card_regs_pkg::*;
(
    output logic                        bus_clk_o,
    output var card_regs_pkg::bus_cmd_t cmd_o
);

    initial begin
        bus_clk_o = 1'b0;
        cmd_o = '0;
    end

    // ----------------------------------------------------------------
    // one command frame
    // ----------------------------------------------------------------
    // clock stands still between frames; released lines show the
    // inverse of the last value so stale data is never mistaken
    task automatic send(input logic [5:0] idx, input logic [31:0] arg,
                        input logic [127:0] data);
        bus_cmd_t c;
        c = {1'b1, idx, arg, data};
        #1.3;
        cmd_o = c;
        #24;
        bus_clk_o = 1'b1;
        #24;
        bus_clk_o = 1'b0;
        cmd_o = ~c;
        #24;
    endtask

endmodule
`default_nettype wire

// >>> card_regs_bench.sv
// self-checking bench for the card address and specific-data bank
`timescale 1ns/1ps
`default_nettype none
module card_regs_bench;
    import card_regs_pkg::*;

    // ----------------------------------------------------------------
    // signals and model state
    // ----------------------------------------------------------------
    localparam logic [15:0] RW_ONCE = 16'hEC00;
    localparam logic [15:0] RW_MANY = 16'h13FE;
    localparam int          LIMIT   = 5000;
    logic         clk_i;
    logic         rst_n_i;
    logic         nv_init_i;
    logic         bus_clk;
    bus_cmd_t     cmd_pin;
    logic [15:0]  rca_o;
    card_state_t  state_o;
    logic         resp_o;
    logic         data_valid_o;
    logic [127:0] data_o;
    logic [127:0] cap;
    logic [127:0] m_img;
    logic [127:0] exp_q[$];
    logic [15:0]  m_rca;
    card_state_t  m_state;
    logic         m_otp;
    logic [15:0]  a;
    logic [31:0]  seed = 32'd62263;
    int mismatches = 0;
    int n_checks = 0;
    int n_resp = 0;
    int n_dv = 0;
    int cycles = 0;
    int f_hi[21] = '{127, 125, 119, 111, 103, 95, 83, 79, 73, 49, 46,
                     41, 36, 31, 28, 25, 21, 121, 75, 20, 0};
    int f_lo[21] = '{126, 122, 112, 104, 96, 84, 80, 77, 62, 47, 42,
                     37, 32, 31, 26, 22, 21, 120, 74, 17, 0};
    int f_v[21]  = '{2'h3, 4'h4, 8'h27, 8'h01, 8'h32, 12'h0F5, 4'h9, 3'h0,
                     12'hFFF, 3'h7, 5'h1F, 5'h1F, 5'h0F, 1'h1, 3'h2, 4'h9,
                     1'h0, 2'h0, 2'h0, 4'h0, 1'h1};

    card_host_model i_host (
        .bus_clk_o (bus_clk),
        .cmd_o     (cmd_pin)
    );

    card_regs i_dut (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .nv_init_i    (nv_init_i),
        .bus_clk_i    (bus_clk),
        .cmd_pin_i    (cmd_pin),
        .rca_o        (rca_o),
        .state_o      (state_o),
        .resp_o       (resp_o),
        .data_valid_o (data_valid_o),
        .data_o       (data_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end

    // pulses are counted here so no one-cycle answer slips by
    always @(posedge clk_i) begin
        cycles = cycles + 1;
        if (resp_o === 1'b1) n_resp = n_resp + 1;
        if (data_valid_o === 1'b1) begin
            n_dv = n_dv + 1;
            cap = data_o;
        end
        if (cycles == LIMIT) begin
            mismatches = mismatches + 1;
            summarize();
        end
    end

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [6:0] crc_of(input logic [127:0] v);
        logic [6:0] r;
        logic       b;
        r = 7'h00;
        for (int i = 127; i >= 8; i--) begin
            b = v[i] ^ r[6];
            r = {r[5:0], 1'b0} ^ (b ? 7'h09 : 7'h00);
        end
        return r;
    endfunction

    task automatic chk(input logic [127:0] got, input logic [127:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic chk_pulse(input int got, input int exp);
        n_checks = n_checks + 1;
        if (got != exp) begin
            mismatches = mismatches + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // ----------------------------------------------------------------
    // one command through model and design
    // ----------------------------------------------------------------
    task automatic cmd(input logic [5:0] idx, input logic [15:0] ad,
                       input logic [127:0] d);
        int r0;
        int v0;
        int er;
        int ev;
        logic [127:0] wm;
        logic [127:0] msk;
        r0 = n_resp;
        v0 = n_dv;
        er = -1;
        ev = 0;
        wm = {112'h0, RW_MANY | (m_otp ? 16'h0000 : RW_ONCE)};
        case (idx)
            CMD_GO_IDLE: begin
                er = 0;
                m_rca = 16'h0001;
                m_state = ST_IDENT;
            end
            CMD_SET_ADDR: begin
                er = (m_state == ST_IDENT && ad != 16'h0000);
                if (er == 1) begin
                    m_rca = ad;
                    m_state = ST_STANDBY;
                end
            end
            CMD_SELECT: begin
                // a selected card answers its own address and stays put
                er = (m_state != ST_IDENT && ad == m_rca);
                if (er == 1 && m_state == ST_STANDBY) m_state = ST_TRANSFER;
                else if (er == 0 && m_state == ST_TRANSFER) begin
                    m_state = ST_STANDBY;
                end
            end
            CMD_SEND_DATA: begin
                ev = (m_state == ST_STANDBY && ad == m_rca);
                er = ev;
                if (ev == 1) exp_q.push_back({m_img[127:1], 1'b1});
            end
            CMD_PROG_DATA: begin
                er = (m_state == ST_TRANSFER);
                if (er == 1) begin
                    m_img = (m_img & ~wm) | (d & wm);
                    m_otp = 1'b1;
                end
            end
            default: er = 0;
        endcase
        i_host.send(idx, {ad, 16'h0000}, d);
        repeat (3) @(posedge clk_i);
        chk(rca_o, m_rca);
        chk(state_o, m_state);
        if (er >= 0) chk_pulse(n_resp - r0, er);
        chk_pulse(n_dv - v0, ev);
        if (ev == 1) begin
            chk(cap, exp_q.pop_front());
            for (int k = 0; k < 21; k++) begin
                msk = (128'h1 << (f_hi[k] - f_lo[k] + 1)) - 128'h1;
                chk((cap >> f_lo[k]) & msk, 128'(f_v[k]));
            end
        end
    endtask

    task automatic hw_reset();
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        m_rca = 16'h0001;
        m_state = ST_IDENT;
        chk(rca_o, m_rca);
        chk(state_o, m_state);
        chk(data_o, 128'h0);
    endtask

    task automatic summarize();
        $display("checks=%0d mismatches=%0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        rst_n_i = 1'b0;
        nv_init_i = 1'b0;
        m_img = CSD_DEFAULT;
        m_img[7:1] = crc_of(CSD_DEFAULT);
        m_otp = 1'b0;
        @(posedge clk_i);
        nv_init_i <= 1'b1;
        @(posedge clk_i);
        nv_init_i <= 1'b0;
        rst_n_i <= 1'b1;
        repeat (6) @(posedge clk_i);
        hw_reset();
        $display("test reset done");
        cmd(CMD_PROG_DATA, 16'h0001, '1);
        cmd(CMD_SEND_DATA, 16'h0001, '0);
        cmd(CMD_SET_ADDR, 16'h0000, '0);
        cmd(6'h3F, 16'h0001, '0);
        $display("test refusals done");
        a = 16'(rnd()) | 16'h8000;
        cmd(CMD_SET_ADDR, a, '0);
        cmd(CMD_SET_ADDR, a ^ 16'h0001, '0);
        cmd(CMD_SEND_DATA, a ^ 16'h0010, '0);
        cmd(CMD_SEND_DATA, a, '0);
        cmd(CMD_SELECT, a, '0);
        cmd(CMD_SELECT, 16'h0000, '0);
        $display("test addressing done");
        for (int k = 0; k < 3; k++) begin
            cmd(CMD_SELECT, a, '0);
            cmd(CMD_PROG_DATA, a, (k == 0) ? '1 : {rnd(), rnd(), rnd(), rnd()});
            cmd(CMD_SELECT, 16'h0000, '0);
            cmd(CMD_SEND_DATA, a, '0);
        end
        $display("test programming done");
        cmd(CMD_GO_IDLE, 16'h0000, '0);
        cmd(CMD_SELECT, 16'h0001, '0);
        cmd(CMD_SET_ADDR, a, '0);
        cmd(CMD_SEND_DATA, a, '0);
        $display("test go-idle done");
        hw_reset();
        cmd(CMD_SET_ADDR, a, '0);
        cmd(CMD_SEND_DATA, a, '0);
        $display("test hardware reset done");
        summarize();
    end

endmodule
`default_nettype wire
